// ### core/sprc_consts.vh
`ifndef SPRC_CONSTS_VH
`define SPRC_CONSTS_VH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SPRC_A_RISE 8'h00
`define SPRC_A_FALL 8'h04
`define SPRC_A_UNIT 8'h08
`define SPRC_A_LOLIM 8'h0c
`define SPRC_A_HILIM 8'h10
`define SPRC_A_TARGET 8'h14
`define SPRC_A_RANGE 8'h18
`define SPRC_A_CT1 8'h1c
`define SPRC_A_CT2 8'h20
`define SPRC_A_CT3 8'h24
`define SPRC_A_SRC 8'h28
`define SPRC_A_MODE 8'h2c
`define SPRC_A_WSP 8'h30
`define SPRC_A_STAT 8'h34
// ----------------------------------------------------------------
// fields, limits and reset values
// ----------------------------------------------------------------
`define SPRC_RATE_MAX 14'h270f
`define SPRC_UNIT_MAX 2'h2
`define SPRC_TYPE_MAX 5'h14
`define SPRC_EVT_MAX 3'h5
`define SPRC_CT_TYPE_LSB 0
`define SPRC_CT_EVT_LSB 5
`define SPRC_SRC_RST 6'h09
`define SPRC_MODE_RST 3'h3
`define SPRC_MODE_RUN 0
`define SPRC_MODE_AUTO 1
`define SPRC_MODE_REV 2
// ----------------------------------------------------------------
// contact operation types
// ----------------------------------------------------------------
`define SPRC_T_GRP1 5'h01
`define SPRC_T_GRP2 5'h02
`define SPRC_T_GRP4 5'h03
`define SPRC_T_READY 5'h07
`define SPRC_T_MANUAL 5'h08
`define SPRC_T_AT 5'h0a
`define SPRC_T_ST 5'h0b
`define SPRC_T_REV 5'h0c
`define SPRC_T_NORAMP 5'h0d
`define SPRC_T_HOLD 5'h0e
`define SPRC_T_MAXH 5'h0f
`define SPRC_T_MINH 5'h10
`define SPRC_T_TIMER 5'h11
`define SPRC_T_UNLATCH 5'h12
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SPRC_CLK_NS 10
`define SPRC_SEC_NS 1000000000
`define SPRC_SEC_CYCLES (`SPRC_SEC_NS / `SPRC_CLK_NS)
`define SPRC_MIN_SECS 12'h03c
`define SPRC_HOUR_SECS 12'he10
`endif

// ### core/sprc_top.v
`timescale 1ns/1ps
`include "sprc_consts.vh"
// Functional notes
// - rate 0 or 0.1..999.9; zero disables ramp
// - rise and fall rates act independently
// - ramp time base second, minute or hour
// - restart from pv at power-on, mode entries
// - auto tuning completion restarts ramp from pv
// - setpoint clamped between low and high limits
// - range type change reloads both limits
// - type 13 on disables ramping
// - disabled ramp jumps to final target
// - three contacts, type 0..20, default 0
// - group number is one plus weights on
// - type 10 starts or stops auto tuning
// - type 12 inverts control action
// - type 18 on releases all latches
// - types 4,5,6,9,19,20 do nothing
// - type 17 timers, all or one event
// - di1, di2 feed contacts 1, 2 by default
module sprc_top #(
   parameter SEC_CYCLES = `SPRC_SEC_CYCLES
) (
   input wire sys_clk,
   input wire arst_n,
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr_stb,
   input wire rd_stb,
   output reg [31:0] rdata_q,
   input wire [1:0] di,
   input wire signed [15:0] process_value,
   input wire signed [15:0] range_low,
   input wire signed [15:0] range_high,
   input wire at_done,
   output reg signed [15:0] setpoint_q,
   output reg [2:0] local_setpoint_group_q,
   output reg run_q,
   output reg auto_q,
   output reg ramp_active_q,
   output reg auto_tuning_q,
   output reg self_tuning_q,
   output reg action_reverse_q,
   output reg latch_release_q,
   output reg [4:0] timer_run_q,
   output reg hold_value_q,
   output reg hold_max_q,
   output reg hold_min_q
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function any_on;
      input [14:0] ty;
      input [2:0] on;
      input [4:0] t;
      integer k;
      begin
         any_on = 1'b0;
         for (k = 0; k < 3; k = k + 1)
            if (on[k] && ty[k*5 +: 5] == t)
               any_on = 1'b1;
      end
   endfunction

   function signed [15:0] clamp;
      input signed [16:0] v;
      input signed [15:0] lo;
      input signed [15:0] hi;
      begin
         if (v < lo)
            clamp = lo;
         else if (v > hi)
            clamp = hi;
         else
            clamp = v[15:0];
      end
   endfunction

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   reg rst_s1_q;
   reg rst_n_q;
   always @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   reg [13:0] rise_q;
   reg [13:0] fall_q;
   reg [1:0] unit_q;
   reg signed [15:0] lolim_q;
   reg signed [15:0] hilim_q;
   reg signed [15:0] target_q;
   reg [7:0] range_q;
   reg [7:0] ct_q [0:2];
   reg [5:0] src_q;
   reg [2:0] mode_q;
   reg init_q;
   wire wr_lo = wr_stb && addr == `SPRC_A_LOLIM;
   wire wr_hi = wr_stb && addr == `SPRC_A_HILIM;
   wire signed [15:0] wval = wdata[15:0];
   integer i;
   integer j;

   always @(posedge sys_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         rise_q <= 14'h0000;
         fall_q <= 14'h0000;
         unit_q <= 2'h0;
         lolim_q <= 16'h0000;
         hilim_q <= 16'h0000;
         target_q <= 16'h0000;
         range_q <= 8'h00;
         for (i = 0; i < 3; i = i + 1)
            ct_q[i] <= 8'h00;
         src_q <= `SPRC_SRC_RST;
         mode_q <= `SPRC_MODE_RST;
         init_q <= 1'b1;
      end
      else
      begin
         init_q <= 1'b0;
         if (wr_stb && addr == `SPRC_A_RISE && wdata[13:0] <= `SPRC_RATE_MAX)
            rise_q <= wdata[13:0];
         if (wr_stb && addr == `SPRC_A_FALL && wdata[13:0] <= `SPRC_RATE_MAX)
            fall_q <= wdata[13:0];
         if (wr_stb && addr == `SPRC_A_UNIT && wdata[1:0] <= `SPRC_UNIT_MAX)
            unit_q <= wdata[1:0];
         if (wr_lo)
            lolim_q <= clamp({wval[15], wval}, range_low, range_high);
         if (wr_hi)
            hilim_q <= clamp({wval[15], wval}, range_low, range_high);
         if (wr_stb && addr == `SPRC_A_TARGET)
            target_q <= wval;
         if (wr_stb && addr == `SPRC_A_RANGE)
            range_q <= wdata[7:0];
         if (init_q || (wr_stb && addr == `SPRC_A_RANGE &&
             wdata[7:0] != range_q))
         begin
            lolim_q <= range_low;
            hilim_q <= range_high;
         end
         for (i = 0; i < 3; i = i + 1)
            if (wr_stb && addr == `SPRC_A_CT1 + 8'h04 * i[7:0] &&
                wdata[4:0] <= `SPRC_TYPE_MAX && wdata[7:5] <= `SPRC_EVT_MAX)
               ct_q[i] <= wdata[7:0];
         if (wr_stb && addr == `SPRC_A_SRC)
            src_q <= wdata[5:0];
         if (wr_stb && addr == `SPRC_A_MODE)
            mode_q <= wdata[2:0];
      end
   end

   // ----------------------------------------------------------------
   // contact decode
   // ----------------------------------------------------------------
   wire [2:0] con;
   wire [14:0] ty;
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1)
      begin : g_ct
         wire [1:0] s = src_q[g*2 +: 2];
         assign con[g] = (s == 2'h1) ? di[0] :
                         (s == 2'h2) ? di[1] : 1'b0;
         assign ty[g*5 +: 5] = ct_q[g][4:0];
      end
   endgenerate

   wire ramp_en = ~any_on(ty, con, `SPRC_T_NORAMP);
   wire run_d = mode_q[`SPRC_MODE_RUN] &
                ~any_on(ty, con, `SPRC_T_READY);
   wire auto_d = mode_q[`SPRC_MODE_AUTO] &
                 ~any_on(ty, con, `SPRC_T_MANUAL);
   wire at_d = any_on(ty, con, `SPRC_T_AT);
   wire [2:0] grp_d = 3'h1 + {2'h0, any_on(ty, con, `SPRC_T_GRP1)} +
                      {1'h0, any_on(ty, con, `SPRC_T_GRP2), 1'b0} +
                      {any_on(ty, con, `SPRC_T_GRP4), 2'h0};

   reg [4:0] timer_d;
   always @*
   begin
      timer_d = timer_run_q;
      for (j = 0; j < 3; j = j + 1)
         if (ty[j*5 +: 5] == `SPRC_T_TIMER)
         begin
            if (ct_q[j][7:5] == 3'h0)
               timer_d = {5{con[j]}};
            else
               timer_d[ct_q[j][7:5] - 3'h1] = con[j];
         end
   end

   // ----------------------------------------------------------------
   // ramp time base
   // ----------------------------------------------------------------
   reg [31:0] cyc_q;
   reg [11:0] sec_q;
   wire sec_end = cyc_q == SEC_CYCLES - 1;
   wire [11:0] base = (unit_q == 2'h1) ? `SPRC_MIN_SECS :
                      (unit_q == 2'h2) ? `SPRC_HOUR_SECS : 12'h001;
   wire tick = sec_end && sec_q >= base - 12'h001;

   // ----------------------------------------------------------------
   // setpoint ramp
   // ----------------------------------------------------------------
   wire signed [15:0] tgt = clamp({target_q[15], target_q},
                                  lolim_q, hilim_q);
   wire signed [16:0] up = {setpoint_q[15], setpoint_q} +
                           {3'h0, rise_q};
   wire signed [16:0] dn = {setpoint_q[15], setpoint_q} -
                           {3'h0, fall_q};
   wire signed [15:0] lo_now = init_q ? range_low : lolim_q;
   wire signed [15:0] hi_now = init_q ? range_high : hilim_q;
   wire restart = init_q | at_done | (auto_tuning_q & ~at_d) |
                  (run_d & auto_d & ((~run_q & auto_q) |
                  (run_q & ~auto_q)));

   always @(posedge sys_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         cyc_q <= 32'h0;
         sec_q <= 12'h000;
         setpoint_q <= 16'h0000;
         ramp_active_q <= 1'b0;
         run_q <= 1'b0;
         auto_q <= 1'b0;
         auto_tuning_q <= 1'b0;
         self_tuning_q <= 1'b0;
         action_reverse_q <= 1'b0;
         latch_release_q <= 1'b0;
         timer_run_q <= 5'h00;
         hold_value_q <= 1'b0;
         hold_max_q <= 1'b0;
         hold_min_q <= 1'b0;
         local_setpoint_group_q <= 3'h1;
      end
      else
      begin
         cyc_q <= sec_end ? 32'h0 : cyc_q + 32'h1;
         if (tick)
            sec_q <= 12'h000;
         else if (sec_end)
            sec_q <= sec_q + 12'h001;
         if (restart)
            setpoint_q <= clamp({process_value[15], process_value},
                                lo_now, hi_now);
         else if (!ramp_en)
            setpoint_q <= tgt;
         else if (setpoint_q < tgt)
         begin
            if (rise_q == 14'h0000)
               setpoint_q <= tgt;
            else if (tick)
               setpoint_q <= (up > tgt) ? tgt : up[15:0];
         end
         else if (setpoint_q > tgt)
         begin
            if (fall_q == 14'h0000)
               setpoint_q <= tgt;
            else if (tick)
               setpoint_q <= (dn < tgt) ? tgt : dn[15:0];
         end
         ramp_active_q <= ramp_en && setpoint_q != tgt &&
                          ((setpoint_q < tgt) ? rise_q != 14'h0000 :
                          fall_q != 14'h0000);
         run_q <= run_d;
         auto_q <= auto_d;
         auto_tuning_q <= at_d;
         self_tuning_q <= any_on(ty, con, `SPRC_T_ST);
         action_reverse_q <= mode_q[`SPRC_MODE_REV] ^
                             any_on(ty, con, `SPRC_T_REV);
         latch_release_q <= any_on(ty, con, `SPRC_T_UNLATCH);
         timer_run_q <= timer_d;
         hold_value_q <= any_on(ty, con, `SPRC_T_HOLD);
         hold_max_q <= any_on(ty, con, `SPRC_T_MAXH);
         hold_min_q <= any_on(ty, con, `SPRC_T_MINH);
         local_setpoint_group_q <= grp_d;
      end
   end

   // ----------------------------------------------------------------
   // register read
   // ----------------------------------------------------------------
   reg [31:0] rd_d;
   always @*
   begin
      case (addr)
         `SPRC_A_RISE: rd_d = {18'h0, rise_q};
         `SPRC_A_FALL: rd_d = {18'h0, fall_q};
         `SPRC_A_UNIT: rd_d = {30'h0, unit_q};
         `SPRC_A_LOLIM: rd_d = {{16{lolim_q[15]}}, lolim_q};
         `SPRC_A_HILIM: rd_d = {{16{hilim_q[15]}}, hilim_q};
         `SPRC_A_TARGET: rd_d = {{16{target_q[15]}}, target_q};
         `SPRC_A_RANGE: rd_d = {24'h0, range_q};
         `SPRC_A_CT1: rd_d = {24'h0, ct_q[0]};
         `SPRC_A_CT2: rd_d = {24'h0, ct_q[1]};
         `SPRC_A_CT3: rd_d = {24'h0, ct_q[2]};
         `SPRC_A_SRC: rd_d = {26'h0, src_q};
         `SPRC_A_MODE: rd_d = {29'h0, mode_q};
         `SPRC_A_WSP: rd_d = {{16{setpoint_q[15]}}, setpoint_q};
         `SPRC_A_STAT: rd_d = {21'h0, con, ramp_en, auto_tuning_q,
                               ramp_active_q, auto_q, run_q,
                               local_setpoint_group_q};
         default: rd_d = 32'h0;
      endcase
   end

   always @(posedge sys_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
         rdata_q <= 32'h0;
      else
         rdata_q <= rd_stb ? rd_d : 32'h0;
   end
endmodule // sprc_top

// ### dv/sprc_checker.sv
`timescale 1ns/1ps
`include "sprc_consts.vh"
// ----------------------------------------
// port checker
// ----------------------------------------
module sprc_checker (
   input wire sys_clk,
   input wire arst_n,
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr_stb,
   input wire [1:0] di,
   input wire signed [15:0] range_low,
   input wire signed [15:0] range_high,
   input wire at_done,
   input wire signed [15:0] setpoint_q,
   input wire [2:0] local_setpoint_group_q,
   input wire run_q,
   input wire auto_q,
   input wire ramp_active_q,
   input wire auto_tuning_q,
   input wire action_reverse_q,
   input wire latch_release_q,
   input wire [4:0] timer_run_q,
   input wire self_tuning_q,
   input wire hold_value_q,
   input wire hold_max_q,
   input wire hold_min_q
);
   reg [7:0] c0;
   reg [7:0] c1;
   reg [2:0] md;
   reg signed [15:0] tgt;
   reg [1:0] di_q;
   reg [2:0] qt;
   wire wok = wdata[4:0] <= 5'h14 && wdata[7:5] <= 3'h5;
   wire [31:0] onv = (di_q[0] ? 32'h1 << c0[4:0] : 32'h0) |
      (di_q[1] ? 32'h1 << c1[4:0] : 32'h0);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);
   // setup shadow; qt counts quiet cycles
   always @(posedge sys_clk or negedge arst_n)
   if (!arst_n)
   begin
      c0 <= 8'h00;
      c1 <= 8'h00;
      md <= 3'h3;
      tgt <= 16'h0000;
      di_q <= 2'h0;
      qt <= 3'h0;
   end
   else
   begin
      di_q <= di;
      qt <= (wr_stb || at_done || di != di_q) ? 3'h0 : qt + {2'h0, ~&qt};
      if (wr_stb && addr == `SPRC_A_CT1 && wok) c0 <= wdata[7:0];
      if (wr_stb && addr == `SPRC_A_CT2 && wok) c1 <= wdata[7:0];
      if (wr_stb && addr == `SPRC_A_MODE) md <= wdata[2:0];
      if (wr_stb && addr == `SPRC_A_TARGET) tgt <= wdata[15:0];
   end
   a_sp_range: assert property
      (setpoint_q >= range_low && setpoint_q <= range_high)
      else $error("setpoint outside input range");
   a_group_sum: assert property (qt[2] |->
      local_setpoint_group_q == 3'h1 + {2'h0, onv[1]} +
      {1'h0, onv[2], 1'h0} + {onv[3], 2'h0})
      else $error("group number wrong");
   a_ramp_off: assert property (qt[2] && onv[13] |->
      setpoint_q == tgt && !ramp_active_q)
      else $error("disabled ramp not at target");
   a_tune_start: assert property (qt[2] |->
      auto_tuning_q == onv[10]) else $error("tuning request wrong");
   a_act_rev: assert property (qt[2] |->
      action_reverse_q == (md[2] ^ onv[12])) else $error("action wrong");
   a_latch_rel: assert property (qt[2] && !wr_stb && di == di_q &&
      onv[18] |-> latch_release_q [*2]) else $error("latch release missing");
   a_mode_sel: assert property (qt[2] |->
      run_q == (md[0] && !onv[7]) && auto_q == (md[1] && !onv[8]))
      else $error("mode wrong");
   a_hold_sel: assert property (qt[2] |->
      {self_tuning_q, hold_value_q, hold_max_q, hold_min_q} ==
      {onv[11], onv[14], onv[15], onv[16]}) else $error("hold wrong");
   a_timer_run: assert property (qt[2] && c0[4:0] == 5'h11 |->
      (c0[7:5] == 3'h0 ? timer_run_q == {5{di_q[0]}} :
      timer_run_q[c0[7:5] - 3'h1] == di_q[0])) else $error("timer wrong");
   c_ramp_done: cover property (ramp_active_q ##1 !ramp_active_q);
   c_ramp_off: cover property (qt[2] && onv[13]);
   c_tune_end: cover property (at_done);
endmodule // sprc_checker
bind sprc_top sprc_checker u_chk (.*);

// ### dv/sprc_partner.sv
`timescale 1ns/1ps
// ----------------------------------------
// contact inputs and process value source
// ----------------------------------------
module sprc_partner (
   input wire sys_clk,
   input wire [1:0] close_req,
   input wire signed [15:0] pv_req,
   output reg [1:0] di = 2'h0,
   output reg signed [15:0] process_value = 16'h00c8
);
   always @(posedge sys_clk)
   begin
      di <= close_req;
      process_value <= pv_req;
   end
endmodule // sprc_partner

// ### dv/sprc_top_tb_top.sv
`timescale 1ns/1ps
`include "sprc_consts.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
   num_errors++; $display("CHECK FAILED at %0t got %h exp %h", \
   $time, g, e); end end
// ----------------------------------------
// bench top
// ----------------------------------------
module sprc_top_tb_top;
   localparam [31:0] H = 32'h0000ffff;
   localparam [7:0] ST = `SPRC_A_STAT;
   reg sys_clk = 1'b0;
   reg arst_n = 1'b0;
   reg [7:0] addr = 8'h00;
   reg [31:0] wdata = 32'h0;
   reg wr_stb = 1'b0;
   reg rd_stb = 1'b0;
   reg rd_q = 1'b0;
   reg at_done = 1'b0;
   reg [1:0] close_req = 2'h0;
   reg [1:0] d;
   reg signed [15:0] pv_req = 16'h00c8;
   wire [1:0] di;
   wire signed [15:0] pv;
   wire [31:0] rdata_q;
   integer num_errors = 0;
   integer comparisons = 0;
   integer i;
   reg [63:0] notes[$];
   reg [63:0] n;
   reg [4:0] idle_t[6] = '{5'h04, 5'h05, 5'h06, 5'h09, 5'h13, 5'h14};
   reg [4:0] hold_t[4] = '{5'h0b, 5'h0e, 5'h0f, 5'h10};
   sprc_top #(.SEC_CYCLES(10)) dut (.sys_clk(sys_clk), .arst_n(arst_n),
      .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rdata_q(rdata_q), .di(di), .process_value(pv),
      .range_low(16'hfc18), .range_high(16'h03e8), .at_done(at_done),
      .setpoint_q(), .local_setpoint_group_q(), .run_q(), .auto_q(),
      .ramp_active_q(), .auto_tuning_q(), .self_tuning_q(),
      .action_reverse_q(), .latch_release_q(), .timer_run_q(),
      .hold_value_q(), .hold_max_q(), .hold_min_q());
   sprc_partner u_far (.sys_clk(sys_clk), .close_req(close_req),
      .pv_req(pv_req), .di(di), .process_value(pv));
   task stop_test;
   begin
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   end
   endtask
   task cyc(input integer k);
      repeat (k) @(posedge sys_clk);
   endtask
   task wr(input [7:0] a, input [31:0] v);
   begin
      @(posedge sys_clk);
      addr <= a;
      wdata <= v;
      wr_stb <= 1'b1;
      @(posedge sys_clk);
      wr_stb <= 1'b0;
   end
   endtask
   task rd(input [7:0] a, input [31:0] m, input [31:0] e);
   begin
      @(posedge sys_clk);
      addr <= a;
      rd_stb <= 1'b1;
      notes.push_back({m, e});
      @(posedge sys_clk);
      rd_stb <= 1'b0;
   end
   endtask
   task pin(input [1:0] v);
   begin
      @(posedge sys_clk);
      close_req <= v;
      cyc(6);
   end
   endtask
   // ----------------------------------------
   // clock, watchdog, read monitor
   // ----------------------------------------
   initial
   begin
      forever #5 sys_clk = ~sys_clk;
   end
   initial
   begin
      #200000;
      num_errors++;
      stop_test;
   end
   always @(posedge sys_clk)
   begin
      if (rd_q)
      begin
         n = notes.pop_front();
         `CHK(rdata_q & n[63:32], n[31:0])
      end
      rd_q <= rd_stb;
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial
   begin
      i = $urandom(32'h0aba);
      cyc(8);
      arst_n <= 1'b1;
      cyc(5);
      rd(`SPRC_A_LOLIM, H, 32'hfc18);
      rd(`SPRC_A_HILIM, H, 32'h03e8);
      for (i = 0; i < 3; i++) rd(8'h1c + 8'h04 * i[7:0], H, 32'h0);
      rd(`SPRC_A_SRC, H, 32'h9);
      rd(`SPRC_A_WSP, H, 32'h0);
      rd(8'h3c, H, 32'h0);
      wr(`SPRC_A_RISE, 32'h2710);
      wr(`SPRC_A_UNIT, 32'h3);
      wr(`SPRC_A_CT1, 32'h15);
      wr(`SPRC_A_CT1, 32'hc0);
      rd(`SPRC_A_RISE, H, 32'h0);
      rd(`SPRC_A_UNIT, H, 32'h0);
      rd(`SPRC_A_CT1, H, 32'h0);
      wr(`SPRC_A_RISE, 32'h32);
      wr(`SPRC_A_TARGET, 32'h190);
      rd(ST, 32'h20, 32'h20);
      cyc(90);
      rd(`SPRC_A_WSP, H, 32'h190);
      wr(`SPRC_A_TARGET, 32'hfffffed4);
      rd(`SPRC_A_WSP, H, 32'hfed4);
      wr(`SPRC_A_FALL, 32'h1e);
      wr(`SPRC_A_RISE, 32'h0);
      wr(`SPRC_A_TARGET, 32'hfffffe7a);
      rd(ST, 32'h20, 32'h20);
      cyc(50);
      rd(`SPRC_A_WSP, H, 32'hfe7a);
      wr(`SPRC_A_UNIT, 32'h2);
      wr(`SPRC_A_TARGET, 32'hfffffe5c);
      cyc(300);
      rd(`SPRC_A_WSP, H, 32'hfe7a);
      wr(`SPRC_A_UNIT, 32'h1);
      cyc(1300);
      rd(`SPRC_A_WSP, H, 32'hfe5c);
      wr(`SPRC_A_CT1, 32'h0d);
      wr(`SPRC_A_RISE, 32'ha);
      wr(`SPRC_A_TARGET, 32'h384);
      rd(ST, 32'ha0, 32'ha0);
      pin(2'h1);
      rd(`SPRC_A_WSP, H, 32'h384);
      rd(ST, 32'ha0, 32'h0);
      pin(2'h0);
      wr(`SPRC_A_CT1, 32'h0);
      wr(`SPRC_A_RISE, 32'h0);
      wr(`SPRC_A_FALL, 32'h0);
      wr(`SPRC_A_LOLIM, 32'h64);
      wr(`SPRC_A_HILIM, 32'h12c);
      rd(`SPRC_A_WSP, H, 32'h12c);
      wr(`SPRC_A_TARGET, 32'hfffffc7c);
      rd(`SPRC_A_WSP, H, 32'h64);
      wr(`SPRC_A_RANGE, 32'h5);
      rd(`SPRC_A_LOLIM, H, 32'hfc18);
      rd(`SPRC_A_HILIM, H, 32'h03e8);
      wr(`SPRC_A_RISE, 32'h5);
      wr(`SPRC_A_FALL, 32'h5);
      wr(`SPRC_A_UNIT, 32'h2);
      pv_req <= 16'h0096;
      wr(`SPRC_A_MODE, 32'h1);
      wr(`SPRC_A_MODE, 32'h3);
      rd(`SPRC_A_WSP, H, 32'h0096);
      pv_req <= 16'h0078;
      wr(`SPRC_A_MODE, 32'h2);
      wr(`SPRC_A_MODE, 32'h3);
      rd(`SPRC_A_WSP, H, 32'h0078);
      pv_req <= 16'h00fa;
      cyc(1);
      at_done <= 1'b1;
      @(posedge sys_clk);
      at_done <= 1'b0;
      rd(`SPRC_A_WSP, H, 32'h00fa);
      wr(`SPRC_A_CT2, 32'h07);
      pin(2'h2);
      rd(ST, 32'h18, 32'h10);
      pv_req <= 16'h003c;
      pin(2'h0);
      rd(`SPRC_A_WSP, H, 32'h003c);
      wr(`SPRC_A_CT2, 32'h08);
      pin(2'h2);
      rd(ST, 32'h18, 32'h08);
      pin(2'h0);
      wr(`SPRC_A_CT2, 32'h0);
      wr(`SPRC_A_CT3, 32'h0a);
      pin(2'h3);
      rd(ST, 32'h40, 32'h0);
      pin(2'h0);
      wr(`SPRC_A_CT3, 32'h0);
      wr(`SPRC_A_CT1, 32'h0a);
      pv_req <= 16'h0050;
      pin(2'h1);
      rd(ST, 32'h40, 32'h40);
      pin(2'h0);
      rd(`SPRC_A_WSP, H, 32'h0050);
      for (i = 0; i < 6; i++)
      begin
         wr(`SPRC_A_CT1, {27'h0, idle_t[i]});
         pin(2'h1);
         rd(ST, 32'h5f, 32'h19);
         pin(2'h0);
      end
      for (i = 0; i < 4; i++)
      begin
         wr(`SPRC_A_CT1, {27'h0, hold_t[i]}); // one hold type
         pin(2'h1);
         pin(2'h0);
      end
      wr(`SPRC_A_CT1, 32'h1); // distinct types only
      wr(`SPRC_A_CT2, 32'h2);
      for (i = 0; i < 8; i++)
      begin
         d = $urandom;
         pin(d);
         rd(ST, 32'h7, 32'h1 + d[0] + 2 * d[1]);
      end
      wr(`SPRC_A_CT2, 32'h3);
      pin(2'h2);
      rd(ST, 32'h7, 32'h5);
      wr(`SPRC_A_CT1, 32'h11);
      wr(`SPRC_A_CT2, 32'h12);
      for (i = 0; i < 6; i++) pin($urandom);
      wr(`SPRC_A_CT1, 32'h71);
      wr(`SPRC_A_CT2, 32'h0c); // no heat/cool here
      for (i = 0; i < 6; i++) pin($urandom);
      cyc(5);
      stop_test;
   end
endmodule // sprc_top_tb_top
